// ==== design/marp_pkg.sv ====
// package: offsets, reset values, field layout and carriers of the alarm/power register bank
package marp_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int THR_W = 12;
    localparam int HYST_W = 8;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [6:0] OFS_RA_UPPER = 7'h64;
    localparam logic [6:0] OFS_RA_LOWER = 7'h65;
    localparam logic [6:0] OFS_RB_UPPER = 7'h66;
    localparam logic [6:0] OFS_RB_LOWER = 7'h67;
    localparam logic [6:0] OFS_AUX_HYST_A = 7'h68;
    localparam logic [6:0] OFS_AUX_HYST_B = 7'h69;
    localparam logic [6:0] OFS_TEMP_HYST = 7'h6A;
    localparam logic [6:0] OFS_POWER = 7'h6B;
    localparam logic [6:0] OFS_MODEL_ID = 7'h6C;
    localparam logic [6:0] OFS_SOFT_RST = 7'h7C;

    // ****************************************
    // reset values and writable-bit masks
    // ****************************************
    localparam logic [15:0] RST_UPPER = 16'h07FF;
    localparam logic [15:0] RST_LOWER = 16'h0800;
    localparam logic [15:0] RST_AUX_HYST = 16'h0810;
    localparam logic [15:0] RST_TEMP_HYST = 16'h2108;
    localparam logic [15:0] RST_POWER = 16'h0000;
    localparam logic [15:0] MASK_THR = 16'h0FFF;
    localparam logic [15:0] MASK_AUX_HYST = 16'h7FFE;
    localparam logic [15:0] MASK_TEMP_HYST = 16'h7FFF;
    localparam logic [15:0] MASK_POWER = 16'h7FFE;
    localparam logic [15:0] SOFT_RST_KEY = 16'h6600;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // ****************************************
    // field positions
    // ****************************************
    localparam int AUX_HI_LSB = 8;
    localparam int AUX_LO_LSB = 1;
    localparam int AUX_HYST_W = 7;
    localparam int RB_HYST_LSB = 10;
    localparam int RA_HYST_LSB = 5;
    localparam int LT_HYST_LSB = 0;
    localparam int TEMP_HYST_W = 5;
    localparam int HYST_FRAC_W = 3;
    localparam int PWR_CONV_BIT = 14;
    localparam int PWR_REF_BIT = 13;
    localparam int PWR_DAC0_BIT = 12;
    localparam int DAC_COUNT = 12;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } marp_req_s;

    typedef struct packed {
        logic [AUX_HYST_W-1:0] aux_input0_hyst;
        logic [AUX_HYST_W-1:0] aux_input1_hyst;
        logic [AUX_HYST_W-1:0] aux_input2_hyst;
        logic [AUX_HYST_W-1:0] aux_input3_hyst;
        logic [HYST_W-1:0] local_temp_hyst;
    } marp_hyst_s;

    typedef struct packed {
        logic converter_power_on;
        logic refbuf_power_on;
        logic [DAC_COUNT-1:0] dac_channel_power_on;
    } marp_power_s;

endpackage : marp_pkg

// ==== design/marp_regbank.sv ====
// monitor alarm thresholds, hysteresis, power control, identity and soft reset registers
//
// Contract
// - threshold top four bits read zero
// - remote A upper at 64h, reset 07FFh
// - remote A lower at 65h, reset 0800h
// - remote B bounds at 66h/67h with resets
// - each alarm uses its own hysteresis
// - aux 0/1 hysteresis at 68h, reset 0810h
// - aux 2/3 hysteresis at 69h, reset 0810h
// - temperature hysteresis fields at 6Ah, 2108h
// - temperature hysteresis is field times eight
// - power register clears to zero at reset
// - bit 14 one runs the converter
// - bit 13 one powers reference buffer
// - bits 12..1 power DAC0..DAC11
// - read-only identity code at 6Ch
// - soft reset restores defaults, DAC data kept
// - hardware reset restores every register
// - four-wire mode: 6600h write resets
// - two-wire mode: any byte write resets
// - out-of-window input sets alarm flag
module marp_regbank
    import marp_pkg::*;
#(
    // arbitrary neutral value, not a real part code
    parameter logic [DATA_W-1:0] MODEL_ID = 16'h5A5A
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic two_wire_mode,
    input wire marp_req_s reg_req,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic remote_sensor_a_valid,
    input wire logic [THR_W-1:0] remote_sensor_a,
    input wire logic remote_sensor_b_valid,
    input wire logic [THR_W-1:0] remote_sensor_b,
    output logic [1:0] input_alarm_flag,
    output marp_hyst_s hyst_cfg,
    output marp_power_s power_ctl,
    output logic soft_reset_pulse
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [DATA_W-1:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    // temperature hysteresis field widened to 0.125 degree units
    function automatic logic [HYST_W-1:0] temp_hyst(input logic [TEMP_HYST_W-1:0] f);
        temp_hyst = {f, {HYST_FRAC_W{1'b0}}};
    endfunction : temp_hyst

    // window check with hysteresis release; two extra bits avoid overflow at the limits
    function automatic logic alarm_next(input logic flag, input logic [THR_W-1:0] t,
                                        input logic [THR_W-1:0] up, input logic [THR_W-1:0] lo,
                                        input logic [HYST_W-1:0] h);
        logic signed [THR_W+1:0] ts;
        logic signed [THR_W+1:0] us;
        logic signed [THR_W+1:0] ls;
        logic signed [THR_W+1:0] hs;
        ts = signed'({{2{t[THR_W-1]}}, t});
        us = signed'({{2{up[THR_W-1]}}, up});
        ls = signed'({{2{lo[THR_W-1]}}, lo});
        hs = signed'({{(THR_W+2-HYST_W){1'b0}}, h});
        // once set, a flag can only clear by crossing back through the hysteresis band
        if (ts > us || ts < ls) begin
            alarm_next = 1'b1;
        end else if (flag && (ts > us - hs || ts < ls + hs)) begin
            alarm_next = 1'b1;
        end else begin
            alarm_next = 1'b0;
        end
    endfunction : alarm_next

    // DAC enables count down from bit 12, so DAC0 sits at the top of the field
    function automatic logic [DAC_COUNT-1:0] dac_map(input logic [DATA_W-1:0] p);
        for (int i = 0; i < DAC_COUNT; i++) begin
            dac_map[i] = p[PWR_DAC0_BIT - i];
        end
    endfunction : dac_map

    // ****************************************
    // register state
    // ****************************************
    logic [DATA_W-1:0] ra_up_q;
    logic [DATA_W-1:0] ra_up_d;
    logic [DATA_W-1:0] ra_lo_q;
    logic [DATA_W-1:0] ra_lo_d;
    logic [DATA_W-1:0] rb_up_q;
    logic [DATA_W-1:0] rb_up_d;
    logic [DATA_W-1:0] rb_lo_q;
    logic [DATA_W-1:0] rb_lo_d;
    logic [DATA_W-1:0] aux_a_q;
    logic [DATA_W-1:0] aux_a_d;
    logic [DATA_W-1:0] aux_b_q;
    logic [DATA_W-1:0] aux_b_d;
    logic [DATA_W-1:0] temp_h_q;
    logic [DATA_W-1:0] temp_h_d;
    logic [DATA_W-1:0] pwr_q;
    logic [DATA_W-1:0] pwr_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic srst_q;
    logic srst_d;
    logic [1:0] alarm_q;
    logic [1:0] alarm_d;
    logic clear_all;

    // ****************************************
    // reset control
    // ****************************************
    // soft reset lands one cycle after the triggering write
    // a register write in the pulse cycle is dropped, a key write there pulses again; the host leaves that cycle idle
    // mode is a steady level from the serial engine on this clock, so no synchroniser
    assign clear_all = !rst_n || srst_q;

    // ****************************************
    // write path
    // ****************************************
    always_comb begin
        ra_up_d = ra_up_q;
        ra_lo_d = ra_lo_q;
        rb_up_d = rb_up_q;
        rb_lo_d = rb_lo_q;
        aux_a_d = aux_a_q;
        aux_b_d = aux_b_q;
        temp_h_d = temp_h_q;
        pwr_d = pwr_q;
        srst_d = 1'b0;
        if (reg_req.wr) begin
            case (reg_req.addr)
                OFS_RA_UPPER: begin
                    ra_up_d = merge(ra_up_q, reg_req.wdata, MASK_THR);
                end
                OFS_RA_LOWER: begin
                    ra_lo_d = merge(ra_lo_q, reg_req.wdata, MASK_THR);
                end
                OFS_RB_UPPER: begin
                    rb_up_d = merge(rb_up_q, reg_req.wdata, MASK_THR);
                end
                OFS_RB_LOWER: begin
                    rb_lo_d = merge(rb_lo_q, reg_req.wdata, MASK_THR);
                end
                OFS_AUX_HYST_A: begin
                    aux_a_d = merge(aux_a_q, reg_req.wdata, MASK_AUX_HYST);
                end
                OFS_AUX_HYST_B: begin
                    aux_b_d = merge(aux_b_q, reg_req.wdata, MASK_AUX_HYST);
                end
                OFS_TEMP_HYST: begin
                    temp_h_d = merge(temp_h_q, reg_req.wdata, MASK_TEMP_HYST);
                end
                OFS_POWER: begin
                    pwr_d = merge(pwr_q, reg_req.wdata, MASK_POWER);
                end
                // key in four-wire mode, any byte in two-wire mode
                OFS_SOFT_RST: begin
                    srst_d = two_wire_mode || (reg_req.wdata == SOFT_RST_KEY);
                end
                default: begin
                    srst_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        // both resets restore every register held here
        if (clear_all) begin
            ra_up_q <= RST_UPPER;
            ra_lo_q <= RST_LOWER;
            rb_up_q <= RST_UPPER;
            rb_lo_q <= RST_LOWER;
            aux_a_q <= RST_AUX_HYST;
            aux_b_q <= RST_AUX_HYST;
            temp_h_q <= RST_TEMP_HYST;
            pwr_q <= RST_POWER;
        end else begin
            ra_up_q <= ra_up_d;
            ra_lo_q <= ra_lo_d;
            rb_up_q <= rb_up_d;
            rb_lo_q <= rb_lo_d;
            aux_a_q <= aux_a_d;
            aux_b_q <= aux_b_d;
            temp_h_q <= temp_h_d;
            pwr_q <= pwr_d;
        end
    end

    // only the hardware reset clears the pulse, so a soft reset ends itself
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            srst_q <= 1'b0;
        end else begin
            srst_q <= srst_d;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // a read and a write in one cycle return the old value
    always_comb begin
        rvalid_d = reg_req.rd;
        rdata_d = ZERO_WORD;
        if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_RA_UPPER: rdata_d = ra_up_q;
                OFS_RA_LOWER: rdata_d = ra_lo_q;
                OFS_RB_UPPER: rdata_d = rb_up_q;
                OFS_RB_LOWER: rdata_d = rb_lo_q;
                OFS_AUX_HYST_A: rdata_d = aux_a_q;
                OFS_AUX_HYST_B: rdata_d = aux_b_q;
                OFS_TEMP_HYST: rdata_d = temp_h_q;
                OFS_POWER: rdata_d = pwr_q;
                OFS_MODEL_ID: rdata_d = MODEL_ID;
                // soft reset register has no readable content
                default: rdata_d = ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= ZERO_WORD;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ****************************************
    // remote sensor alarms
    // ****************************************
    always_comb begin
        alarm_d = alarm_q;
        // remote A with its own hysteresis
        if (remote_sensor_a_valid) begin
            alarm_d[0] = alarm_next(alarm_q[0], remote_sensor_a, ra_up_q[THR_W-1:0],
                ra_lo_q[THR_W-1:0], temp_hyst(temp_h_q[RA_HYST_LSB +: TEMP_HYST_W]));
        end
        // remote B with its own hysteresis
        if (remote_sensor_b_valid) begin
            alarm_d[1] = alarm_next(alarm_q[1], remote_sensor_b, rb_up_q[THR_W-1:0],
                rb_lo_q[THR_W-1:0], temp_hyst(temp_h_q[RB_HYST_LSB +: TEMP_HYST_W]));
        end
    end

    // soft reset drops the flags too, so none outlives its thresholds
    always_ff @(posedge mclk) begin
        if (clear_all) begin
            alarm_q <= 2'h0;
        end else begin
            alarm_q <= alarm_d;
        end
    end

    // ****************************************
    // outputs, all from flops
    // ****************************************
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign input_alarm_flag = alarm_q;
    assign soft_reset_pulse = srst_q;

    // ****************************************
    // hysteresis and power fields
    // ****************************************
    // aux fields in raw code steps
    assign hyst_cfg.aux_input0_hyst = aux_a_q[AUX_HI_LSB +: AUX_HYST_W];
    assign hyst_cfg.aux_input1_hyst = aux_a_q[AUX_LO_LSB +: AUX_HYST_W];
    assign hyst_cfg.aux_input2_hyst = aux_b_q[AUX_HI_LSB +: AUX_HYST_W];
    assign hyst_cfg.aux_input3_hyst = aux_b_q[AUX_LO_LSB +: AUX_HYST_W];
    // local hysteresis low three bits forced zero
    assign hyst_cfg.local_temp_hyst = temp_hyst(temp_h_q[LT_HYST_LSB +: TEMP_HYST_W]);

    assign power_ctl.converter_power_on = pwr_q[PWR_CONV_BIT];
    assign power_ctl.refbuf_power_on = pwr_q[PWR_REF_BIT];
    // DAC order runs downward from bit 12
    assign power_ctl.dac_channel_power_on = dac_map(pwr_q);

endmodule : marp_regbank

// ==== testbench/marp_host_model.sv ====
// host-side model issuing register strobes, one access every other cycle
module marp_host_model
    import marp_pkg::*;
(
    input wire logic mclk,
    output marp_req_s reg_req,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial reg_req = '0;
    // the idle cycle after each access keeps a write out of the soft reset cycle
    task automatic access(input logic w, input logic [6:0] a, input logic [15:0] d,
            output logic [15:0] q);
        @(negedge mclk);
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = reg_rvalid ? reg_rdata : 16'hXXXX;
    endtask : access
endmodule : marp_host_model

// ==== testbench/marp_regbank_sva.sv ====
// concurrent checks on the ports of the alarm/power register bank
module marp_regbank_chk
    import marp_pkg::*;
#(
    parameter logic [DATA_W-1:0] MODEL_ID = 16'h5A5A
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic two_wire_mode,
    input wire marp_req_s reg_req,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic remote_sensor_a_valid,
    input wire logic remote_sensor_b_valid,
    input wire logic [1:0] input_alarm_flag,
    input wire marp_hyst_s hyst_cfg,
    input wire marp_power_s power_ctl,
    input wire logic soft_reset_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic key_q;
    logic [DATA_W-1:0] wd_q;
    logic [11:0] dac_x;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // write data of the previous cycle kept so a write can be compared with its effect
    always_ff @(posedge mclk) begin
        wd_q <= reg_req.wdata;
        key_q <= rst_n && reg_req.wr && reg_req.addr == 7'h7C
            && (two_wire_mode || reg_req.wdata == 16'h6600);
    end
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            dac_x[i] = wd_q[12 - i];
        end
    end
    sequence key_wr;
        reg_req.wr && reg_req.addr == 7'h7C && (two_wire_mode || reg_req.wdata == 16'h6600);
    endsequence
    sequence back_to_dflt;
        soft_reset_pulse ##1 (power_ctl == 14'h0000 && input_alarm_flag == 2'b00
            && hyst_cfg.local_temp_hyst == 8'h40);
    endsequence
    rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read not answered one cycle later");
    idle_zero_a: assert property (!reg_req.rd |=> !reg_rvalid && reg_rdata == 16'h0000)
        else $error("read data driven without a read");
    thr_top_a: assert property (reg_req.rd && reg_req.addr inside {[7'h64:7'h67]}
        |=> reg_rdata[15:12] == 4'h0) else $error("threshold top bits not zero");
    id_read_a: assert property (reg_req.rd && reg_req.addr == 7'h6C
        |=> reg_rdata == MODEL_ID) else $error("identity code wrong");
    soft_seq_a: assert property (key_wr |=> back_to_dflt)
        else $error("soft reset did not restore defaults");
    soft_cause_a: assert property (soft_reset_pulse == key_q)
        else $error("soft reset pulse without matching write");
    pwr_map_a: assert property (reg_req.wr && reg_req.addr == 7'h6B && !soft_reset_pulse
        |=> power_ctl == {wd_q[14:13], dac_x}) else $error("power bits mapped wrongly");
    temp_hyst_a: assert property (reg_req.wr && reg_req.addr == 7'h6A && !soft_reset_pulse
        |=> hyst_cfg.local_temp_hyst == {wd_q[4:0], 3'b000}) else $error("local hysteresis wrong");
    aux_hyst_a: assert property (reg_req.wr && reg_req.addr == 7'h68 && !soft_reset_pulse
        |=> hyst_cfg.aux_input0_hyst == wd_q[14:8] && hyst_cfg.aux_input1_hyst == wd_q[7:1])
        else $error("aux hysteresis fields wrong");
    alarm_hold_a: assert property (!remote_sensor_a_valid && !remote_sensor_b_valid
        && !soft_reset_pulse |=> $stable(input_alarm_flag))
        else $error("alarm moved without sample");
endmodule : marp_regbank_chk

// ==== testbench/testbench.sv ====
// self-checking bench for the alarm/power register bank
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module testbench
    import marp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // arbitrary identity value, not a real part code
    localparam logic [15:0] ID_CODE = 16'h3C96;
    localparam logic [6:0] ADDRS [11] = '{7'h64, 7'h65, 7'h66, 7'h67, 7'h68, 7'h69, 7'h6A,
        7'h6B, 7'h6C, 7'h7C, 7'h70};
    logic mclk = 1'b0, rst_n = 1'b0, two_wire_mode = 1'b0, sa_v = 1'b0, sb_v = 1'b0;
    logic [11:0] sa = 12'h000, sb = 12'h000;
    logic [15:0] reg_rdata, q;
    logic reg_rvalid, soft_reset_pulse;
    logic [1:0] input_alarm_flag, fl;
    marp_req_s reg_req;
    marp_hyst_s hyst_cfg;
    marp_power_s power_ctl;
    logic [15:0] m [logic [6:0]];
    int fails = 0, comparisons = 0;
    always #2 mclk = ~mclk;
    marp_regbank #(.MODEL_ID(ID_CODE)) u_marp_regbank (.mclk(mclk), .rst_n(rst_n),
        .two_wire_mode(two_wire_mode), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .remote_sensor_a_valid(sa_v), .remote_sensor_a(sa),
        .remote_sensor_b_valid(sb_v), .remote_sensor_b(sb), .input_alarm_flag(input_alarm_flag),
        .hyst_cfg(hyst_cfg), .power_ctl(power_ctl), .soft_reset_pulse(soft_reset_pulse));
    marp_host_model u_host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    // ****************************************
    // reference model
    // ****************************************
    task automatic dflt();
        m[7'h64] = 16'h07FF;
        m[7'h66] = 16'h07FF;
        m[7'h65] = 16'h0800;
        m[7'h67] = 16'h0800;
        m[7'h68] = 16'h0810;
        m[7'h69] = 16'h0810;
        m[7'h6A] = 16'h2108;
        m[7'h6B] = 16'h0000;
        fl = 2'b00;
    endtask : dflt
    function automatic logic [15:0] mask(logic [6:0] a);
        if (a < 7'h68) return 16'h0FFF;
        if (a == 7'h6A) return 16'h7FFF;
        return 16'h7FFE;
    endfunction : mask
    function automatic int s12(logic [11:0] x);
        return int'($signed(x));
    endfunction : s12
    function automatic logic alarm(logic f, int t, int up, int lo, int h);
        return (t > up || t < lo) || (f && (t > up - h || t < lo + h));
    endfunction : alarm
    task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
        u_host.access(1'b1, a, d, q);
        if (a == 7'h7C && (two_wire_mode || d == 16'h6600)) dflt();
        else if (m.exists(a)) m[a] = d & mask(a);
    endtask : reg_write
    task automatic check_all(input string name);
        marp_power_s px;
        logic [15:0] exp_v;
        px = {m[7'h6B][14:13], 12'h000};
        for (int i = 0; i < 12; i++) px.dac_channel_power_on[i] = m[7'h6B][12 - i];
        foreach (ADDRS[i]) begin
            u_host.access(1'b0, ADDRS[i], 16'h0000, q);
            exp_v = m.exists(ADDRS[i]) ? m[ADDRS[i]] : 16'h0000;
            exp_v = ADDRS[i] == 7'h6C ? ID_CODE : exp_v;
            `CHK(q, exp_v)
        end
        `CHK(power_ctl, px)
        `CHK(hyst_cfg, ({m[7'h68][14:1], m[7'h69][14:1], m[7'h6A][4:0], 3'b000}))
        `CHK(input_alarm_flag, fl)
        $display("%s done", name);
    endtask : check_all
    task automatic sample(input logic [11:0] a, input logic [11:0] b);
        @(negedge mclk);
        {sa, sb, sa_v, sb_v} = {a, b, 2'b11};
        fl[0] = alarm(fl[0], s12(a), s12(m[7'h64][11:0]), s12(m[7'h65][11:0]), 8 * m[7'h6A][9:5]);
        fl[1] = alarm(fl[1], s12(b), s12(m[7'h66][11:0]), s12(m[7'h67][11:0]), 8 * m[7'h6A][14:10]);
        @(negedge mclk);
        {sa, sb, sa_v, sb_v} = {~a, ~b, 2'b00};
        `CHK(input_alarm_flag, fl)
    endtask : sample
    task automatic complete_run();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h5742B89D));
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        dflt();
        check_all("reset values");
        repeat (3) foreach (ADDRS[i]) if (ADDRS[i] != 7'h7C) reg_write(ADDRS[i], 16'($urandom));
        check_all("random writes");
        reg_write(7'h64, 16'h0064);
        reg_write(7'h65, 16'h0000);
        reg_write(7'h66, 16'h0010);
        reg_write(7'h67, 16'h0FF0);
        reg_write(7'h6A, 16'h0428);
        // hysteresis of one degree: set, hold inside the margin, then clear
        sample(12'h065, 12'hFEF);
        sample(12'h05F, 12'hFF7);
        sample(12'h05A, 12'hFF8);
        repeat (40) sample(12'($urandom_range(255)) - 12'h080, 12'($urandom_range(255)) - 12'h080);
        check_all("alarm window");
        reg_write(7'h7C, 16'h1234);
        check_all("wrong key kept");
        reg_write(7'h7C, 16'h6600);
        check_all("four-wire reset");
        reg_write(7'h6B, 16'($urandom));
        two_wire_mode = 1'b1;
        reg_write(7'h7C, 16'($urandom));
        check_all("two-wire reset");
        reg_write(7'h69, 16'($urandom));
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        dflt();
        check_all("hardware reset");
        complete_run();
    end
endmodule : testbench
bind marp_regbank marp_regbank_chk #(.MODEL_ID(MODEL_ID)) u_chk (.mclk(mclk), .rst_n(rst_n),
    .two_wire_mode(two_wire_mode), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .remote_sensor_a_valid(remote_sensor_a_valid),
    .remote_sensor_b_valid(remote_sensor_b_valid), .input_alarm_flag(input_alarm_flag),
    .hyst_cfg(hyst_cfg), .power_ctl(power_ctl), .soft_reset_pulse(soft_reset_pulse));
